// File: core/adcic_top.sv
`timescale 1ns/1ps
`default_nettype none
module adcic_top
    import adcic_pkg::*;
(
    input  wire logic                 clock_i,
    input  wire logic                 nrst_i,
    input  wire logic [11:0]          addr_i,
    input  wire logic [7:0]           wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [7:0]           rdata_o,
    input  wire logic [ADCIC_RES_W-1:0] conv_result_i,
    output logic                      conv_sample_o,
    output var adcic_analog_t         analog_o
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]             chan_ctrl;
    logic [7:0]             buf_ctrl;
    logic [ADCIC_RES_W-1:0] result;
    logic [3:0]             chan_q;
    logic [2:0]             mode_q;
    logic                   sample;
    logic                   done;
    logic                   busy;
    logic                   start;
    logic [7:0]             pos_sw;
    logic [7:0]             neg_sw;
    logic                   gnd_amp;
    logic                   temp_sel;
    logic                   cal;

    assign start = wr_i && (addr_i == ADCIC_CHAN_CTRL_ADDR) && wdata_i[ADCIC_GO_BIT];

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chan_ctrl <= ADCIC_CHAN_CTRL_RST;
        end else begin
            if (wr_i && addr_i == ADCIC_CHAN_CTRL_ADDR) begin
                chan_ctrl[6:0] <= wdata_i[6:0];
            end
            if (start) begin
                chan_ctrl[ADCIC_GO_BIT] <= 1'b1;
            end else if (done) begin
                chan_ctrl[ADCIC_GO_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            buf_ctrl <= ADCIC_BUF_CTRL_RST;
        end else if (wr_i && addr_i == ADCIC_BUF_CTRL_ADDR) begin
            buf_ctrl <= wdata_i;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chan_q <= 4'h0;
            mode_q <= 3'h0;
        end else if (start) begin
            // the start write carries the channel, so switches and interval agree
            chan_q <= wdata_i[3:0];
            mode_q <= buf_ctrl[2:0];
        end
    end

    adcic_seq u_seq (
        .clock_i  (clock_i),
        .nrst_i   (nrst_i),
        .start_i  (start),
        .repeat_conversion_i   (wdata_i[ADCIC_REPEAT_CONVERSION_BIT]),
        .temp_i   (wdata_i[3:0] == ADCIC_CH_TEMP && buf_ctrl[2:1] == 2'b00),
        .sample_o (sample),
        .done_o   (done),
        .busy_o   (busy)
    );

    adcic_route u_route (
        .chan_i    (chan_q),
        .bufmode_i (mode_q),
        .pos_sw_o  (pos_sw),
        .neg_sw_o  (neg_sw),
        .gnd_amp_o (gnd_amp),
        .temp_o    (temp_sel),
        .cal_o     (cal)
    );

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result <= '0;
        end else if (sample) begin
            result <= conv_result_i;
        end
    end

    assign conv_sample_o = sample;

    // ------------------------------------------------------------
    // analog outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            analog_o <= '{pos_sw: 8'h00, neg_sw: 8'h00, gnd_amp_in: 1'b0,
                          temp_sel: 1'b0, offset_cal: 1'b0, buffered: 1'b0,
                          differential: 1'b0, ref_level: ADCIC_REF_2V0,
                          ref_drive: 1'b0};
        end else begin
            analog_o.pos_sw       <= busy ? pos_sw : 8'h00;
            analog_o.neg_sw       <= busy ? neg_sw : 8'h00;
            analog_o.gnd_amp_in   <= busy && gnd_amp;
            analog_o.temp_sel     <= busy && temp_sel;
            analog_o.offset_cal   <= busy && cal;
            analog_o.buffered     <= mode_q[0];
            analog_o.differential <= mode_q[2];
            analog_o.ref_level    <= adcic_ref_t'({buf_ctrl[ADCIC_REFHI_BIT],
                                                   chan_ctrl[ADCIC_REFLO_BIT]});
            analog_o.ref_drive    <= chan_ctrl[ADCIC_REF_DRIVE_OUT_BIT];
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            unique case (addr_i)
                ADCIC_CHAN_CTRL_ADDR: rdata_o <= chan_ctrl;
                ADCIC_BUF_CTRL_ADDR:  rdata_o <= buf_ctrl;
                ADCIC_DATA_HI_ADDR:   rdata_o <= result[12:5];
                ADCIC_DATA_LO_ADDR:   rdata_o <= {result[4:0], 3'b000};
                default:              rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule : adcic_top
`default_nettype wire

// File: core/adcic_pkg.sv
// Behaviour
// - writing convert_go one starts or restarts conversion
// - result is thirteen-bit two's complement
// - single-shot result once after 5129 cycles
// - continuous: first 5129, then every 256
// - temperature sensor doubles every interval
// - channel meaning depends on buffer mode
// - single-ended codes 0-7 select pins 0-7
// - code 1100 grounds pins 1,2; 1110 temperature
// - differential codes 0-7 select fixed pin pairs
// - differential code 1111 is offset calibration
// - reserved codes open all input switches
// - reference level: external, 1.0V, 2.0V, reserved
// - reset reference level defaults to 2.0V
// - reference independent of comparator reference
// - buffer mode decode, reserved codes listed
// - buffer register resets to 0x80
package adcic_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADCIC_CHAN_CTRL_ADDR = 12'hF70;
    localparam logic [11:0] ADCIC_BUF_CTRL_ADDR  = 12'hF71;
    localparam logic [11:0] ADCIC_DATA_HI_ADDR   = 12'hF72;
    localparam logic [11:0] ADCIC_DATA_LO_ADDR   = 12'hF73;

    localparam logic [7:0] ADCIC_CHAN_CTRL_RST = 8'h00;
    localparam logic [7:0] ADCIC_BUF_CTRL_RST  = 8'h80;

    localparam int ADCIC_GO_BIT     = 7;
    localparam int ADCIC_REFLO_BIT  = 6;
    localparam int ADCIC_REF_DRIVE_OUT_BIT = 5;
    localparam int ADCIC_REPEAT_CONVERSION_BIT   = 4;
    localparam int ADCIC_REFHI_BIT  = 7;

    // ------------------------------------------------------------
    // timing, channel codes and result width
    // ------------------------------------------------------------
    localparam int          ADCIC_FIRST_CYCLES  = 5129;
    localparam int          ADCIC_REPEAT_CYCLES = 256;
    localparam int          ADCIC_CNT_W         = 14;
    localparam logic [3:0]  ADCIC_CH_TEMP       = 4'hE;
    localparam logic [3:0]  ADCIC_CH_GND        = 4'hC;
    localparam logic [3:0]  ADCIC_CH_CAL        = 4'hF;
    localparam int          ADCIC_RES_W         = 13;

    typedef enum logic [1:0] {
        ADCIC_REF_EXT,
        ADCIC_REF_1V0,
        ADCIC_REF_2V0,
        ADCIC_REF_RSVD
    } adcic_ref_t;

    // analog switch and mode controls toward the converter core
    typedef struct packed {
        logic [7:0] pos_sw;
        logic [7:0] neg_sw;
        logic       gnd_amp_in;
        logic       temp_sel;
        logic       offset_cal;
        logic       buffered;
        logic       differential;
        adcic_ref_t ref_level;
        logic       ref_drive;
    } adcic_analog_t;

endpackage : adcic_pkg

// File: core/adcic_route.sv
`timescale 1ns/1ps
`default_nettype none
module adcic_route
    import adcic_pkg::*;
(
    input  wire logic [3:0] chan_i,
    input  wire logic [2:0] bufmode_i,
    output logic      [7:0] pos_sw_o,
    output logic      [7:0] neg_sw_o,
    output logic            gnd_amp_o,
    output logic            temp_o,
    output logic            cal_o
);
    logic legal_mode;
    logic diff;

    assign legal_mode = (bufmode_i[1] == 1'b0);
    assign diff       = bufmode_i[2];

    always_comb begin
        pos_sw_o  = 8'h00;
        neg_sw_o  = 8'h00;
        gnd_amp_o = 1'b0;
        temp_o    = 1'b0;
        cal_o     = 1'b0;
        if (legal_mode) begin
            if (!diff) begin
                if (chan_i[3] == 1'b0) begin
                    pos_sw_o[chan_i[2:0]] = 1'b1;
                end
                if (chan_i == ADCIC_CH_GND) begin
                    gnd_amp_o = 1'b1;
                end
                if (chan_i == ADCIC_CH_TEMP) begin
                    temp_o = 1'b1;
                end
            end else begin
                unique case (chan_i)
                    4'h0: begin
                        pos_sw_o[0] = 1'b1;
                        neg_sw_o[1] = 1'b1;
                    end
                    4'h1: begin
                        pos_sw_o[2] = 1'b1;
                        neg_sw_o[3] = 1'b1;
                    end
                    4'h2: begin
                        pos_sw_o[4] = 1'b1;
                        neg_sw_o[5] = 1'b1;
                    end
                    4'h3: begin
                        pos_sw_o[1] = 1'b1;
                        neg_sw_o[0] = 1'b1;
                    end
                    4'h4: begin
                        pos_sw_o[3] = 1'b1;
                        neg_sw_o[2] = 1'b1;
                    end
                    4'h5: begin
                        pos_sw_o[5] = 1'b1;
                        neg_sw_o[4] = 1'b1;
                    end
                    4'h6: begin
                        pos_sw_o[6] = 1'b1;
                        neg_sw_o[5] = 1'b1;
                    end
                    4'h7: begin
                        pos_sw_o[0] = 1'b1;
                        neg_sw_o[2] = 1'b1;
                    end
                    4'hF: cal_o = 1'b1;
                    default: ;
                endcase
            end
        end
    end
endmodule : adcic_route
`default_nettype wire

// File: core/adcic_seq.sv
`timescale 1ns/1ps
`default_nettype none
module adcic_seq
    import adcic_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic nrst_i,
    input  wire logic start_i,
    input  wire logic repeat_conversion_i,
    input  wire logic temp_i,
    output logic      sample_o,
    output logic      done_o,
    output logic      busy_o
);
    localparam logic [ADCIC_CNT_W-1:0] FIRST  = ADCIC_CNT_W'(ADCIC_FIRST_CYCLES);
    localparam logic [ADCIC_CNT_W-1:0] REPEAT = ADCIC_CNT_W'(ADCIC_REPEAT_CYCLES);

    typedef enum logic [1:0] {S_IDLE, S_FIRST, S_REPEAT} adcic_state_t;
    adcic_state_t state;
    logic [ADCIC_CNT_W:0] cnt;
    logic                 temp_q;
    logic                 repeat_conversion_q;
    logic [ADCIC_CNT_W:0] limit;

    always_comb begin
        limit = (state == S_REPEAT) ? {1'b0, REPEAT} : {1'b0, FIRST};
        if (temp_q) begin
            limit = {limit[ADCIC_CNT_W-1:0], 1'b0};
        end
    end

    assign busy_o   = (state != S_IDLE);
    assign sample_o = busy_o && (cnt == limit);

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state  <= S_IDLE;
            cnt    <= '0;
            temp_q <= 1'b0;
            repeat_conversion_q <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                state  <= S_FIRST;
                cnt    <= (ADCIC_CNT_W+1)'(1);
                temp_q <= temp_i;
                repeat_conversion_q <= repeat_conversion_i;
            end else begin
                unique case (state)
                    S_IDLE: ;
                    S_FIRST, S_REPEAT: begin
                        if (cnt == limit) begin
                            cnt <= (ADCIC_CNT_W+1)'(1);
                            if (state == S_FIRST) begin
                                done_o <= 1'b1;
                            end
                            state <= repeat_conversion_q ? S_REPEAT : S_IDLE;
                        end else begin
                            cnt <= cnt + (ADCIC_CNT_W+1)'(1);
                        end
                    end
                endcase
            end
        end
    end
endmodule : adcic_seq
`default_nettype wire

// File: testbench/adcic_props.sv
`timescale 1ns/1ps
`default_nettype none
module adcic_props
    import adcic_pkg::*;
(
    input wire logic                   clock_i,
    input wire logic                   nrst_i,
    input wire logic [11:0]            addr_i,
    input wire logic [7:0]             wdata_i,
    input wire logic                   wr_i,
    input wire logic                   rd_i,
    input wire logic [7:0]             rdata_o,
    input wire logic [ADCIC_RES_W-1:0] conv_result_i,
    input wire logic                   conv_sample_o,
    input wire adcic_analog_t          analog_o
);
    // ------------------------------------------------------------
    // interval counter
    // ------------------------------------------------------------
    // saturates so a stray pulse long after any start still fails
    logic [13:0] gap;
    wire logic   go_wr = wr_i && addr_i == ADCIC_CHAN_CTRL_ADDR && wdata_i[ADCIC_GO_BIT];

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gap <= 14'h3FFF;
        end else if (go_wr || conv_sample_o) begin
            gap <= 14'h0000;
        end else if (gap != 14'h3FFF) begin
            gap <= gap + 14'h0001;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);

    a_sample_gap: assert property (
        conv_sample_o |-> gap inside {14'h00FF, 14'h01FF, 14'h1408, 14'h2811})
        else $error("result pulse at wrong interval");
    a_go_readback: assert property (
        (go_wr ##1 (rd_i && addr_i == ADCIC_CHAN_CTRL_ADDR)) |=> rdata_o[ADCIC_GO_BIT])
        else $error("go bit not set after start");
    a_buf_readback: assert property (
        ((wr_i && addr_i == ADCIC_BUF_CTRL_ADDR) ##1 (rd_i && addr_i == ADCIC_BUF_CTRL_ADDR))
        |=> rdata_o == $past(wdata_i, 2))
        else $error("buffer register readback wrong");
    a_ref_reset: assert property (
        !$past(nrst_i) |-> analog_o.ref_level == ADCIC_REF_2V0)
        else $error("reference level not 2.0V after reset");
    a_cal_diff: assert property (
        analog_o.offset_cal |-> analog_o.differential)
        else $error("calibration outside differential mode");
    a_gnd_single: assert property (
        analog_o.gnd_amp_in |-> !analog_o.differential && !analog_o.temp_sel)
        else $error("grounding in wrong mode");
    a_temp_single: assert property (
        analog_o.temp_sel |-> !analog_o.differential)
        else $error("temperature sensor in differential mode");
    a_pos_onehot: assert property (
        $onehot0(analog_o.pos_sw))
        else $error("several positive switches closed");
    a_neg_onehot: assert property (
        $onehot0(analog_o.neg_sw))
        else $error("several negative switches closed");
endmodule : adcic_props

bind adcic_top adcic_props i_adcic_props (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .conv_result_i(conv_result_i), .conv_sample_o(conv_sample_o), .analog_o(analog_o));
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import adcic_pkg::*;
;
    // ------------------------------------------------------------
    // setup
    // ------------------------------------------------------------
    localparam logic [12:0] RES  = 13'h1A5B;
    // pin numbers of the differential pairs, code 7 leftmost
    localparam logic [23:0] PPOS = {3'h0, 3'h6, 3'h5, 3'h3, 3'h1, 3'h4, 3'h2, 3'h0};
    localparam logic [23:0] PNEG = {3'h2, 3'h5, 3'h4, 3'h2, 3'h0, 3'h5, 3'h3, 3'h1};
    localparam logic [11:0] CH   = ADCIC_CHAN_CTRL_ADDR;
    localparam logic [11:0] BF   = ADCIC_BUF_CTRL_ADDR;

    logic                   clock_i       = 1'b0;
    logic                   nrst_i        = 1'b0;
    logic [11:0]            addr_i        = 12'h000;
    logic [7:0]             wdata_i       = 8'h00;
    logic                   wr_i          = 1'b0;
    logic                   rd_i          = 1'b0;
    logic [7:0]             rdata_o;
    logic [ADCIC_RES_W-1:0] conv_result_i = RES;
    logic                   conv_sample_o;
    adcic_analog_t          analog_o;
    logic [7:0]             rv;
    int                     n_fail        = 0;
    int                     total_checks  = 0;
    int                     cyc           = 0;
    int                     t0;

    adcic_top i_adcic_top (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .conv_result_i(conv_result_i), .conv_sample_o(conv_sample_o), .analog_o(analog_o));

    always #2 clock_i = ~clock_i;

    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // hold keeps the strobe up for a write that follows at once
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic hold);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clock_i);
        if (!hold) begin
            wr_i <= 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(posedge clock_i);
        d = rdata_o;
    endtask : rd

    // edges from t0 to the next result pulse, or lim if none comes
    task automatic wait_gap(input int lim, input int exp);
        @(posedge clock_i);
        while (conv_sample_o !== 1'b1 && cyc - t0 < lim) begin
            @(posedge clock_i);
        end
        chk(24'(cyc - t0), 24'(exp));
        t0 = cyc;
    endtask : wait_gap

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd(CH, rv);
        chk(rv, 8'h00);
        rd(BF, rv);
        chk(rv, 8'h80);
        rd(12'hF7F, rv);
        chk(rv, 8'h00);
        wr(BF, 8'h85, 1'b0);
        rd(BF, rv);
        chk(rv, 8'h85);
        wr(CH, 8'h13, 1'b0);
        rd(CH, rv);
        chk(rv, 8'h13);
    endtask : t_regs

    // restarts before completion, so each code costs a few cycles only
    task automatic t_route();
        logic [2:0] m;
        logic [3:0] c;
        logic       d;
        logic       lg;
        logic       sp;
        for (int k = 0; k < 128; k++) begin
            m  = {k[5], k[6], k[4]};
            c  = k[3:0];
            d  = m[2];
            lg = !m[1];
            wr(BF, {k[0], 4'h0, m}, 1'b1);
            wr(CH, {1'b0, k[1], k[2], 1'b0, c}, 1'b1);
            wr(CH, {1'b1, k[1], k[2], 1'b0, c}, 1'b0);
            repeat (3) @(posedge clock_i);
            chk({analog_o.gnd_amp_in, analog_o.temp_sel, analog_o.offset_cal, analog_o.buffered,
                analog_o.differential, analog_o.ref_level, analog_o.ref_drive},
                {lg && !d && c == ADCIC_CH_GND, lg && !d && c == ADCIC_CH_TEMP,
                 lg && d && c == ADCIC_CH_CAL, m[0], d, k[0], k[1],
                 k[2]});
            sp = lg && (d ? c == ADCIC_CH_CAL : c == ADCIC_CH_GND || c == ADCIC_CH_TEMP);
            if (!sp) begin
                chk({analog_o.pos_sw, analog_o.neg_sw}, (c[3] || !lg) ? 16'h0000 : d ?
                    {8'h01 << PPOS[c*3 +: 3], 8'h01 << PNEG[c*3 +: 3]} :
                    {8'h01 << c, 8'h00});
            end
        end
    endtask : t_route

    task automatic t_single();
        wr(BF, 8'h80, 1'b1);
        wr(CH, 8'h03, 1'b1);
        wr(CH, 8'h83, 1'b0);
        t0 = cyc;
        rd(CH, rv);
        chk(rv, 8'h83);
        wr(CH, 8'h05, 1'b0);
        rd(CH, rv);
        chk(rv, 8'h85);
        chk(analog_o.pos_sw, 8'h08);
        wait_gap(9000, 5129);
        conv_result_i <= ~RES;
        rd(ADCIC_DATA_HI_ADDR, rv);
        chk(rv, RES[12:5]);
        rd(ADCIC_DATA_LO_ADDR, rv);
        chk(rv, {RES[4:0], 3'h0});
        rd(CH, rv);
        chk(rv, 8'h05);
        wait_gap(600, 600);
        rd(ADCIC_DATA_HI_ADDR, rv);
        chk(rv, RES[12:5]);
        conv_result_i <= RES;
    endtask : t_single

    task automatic t_repeat_conversion(input logic [7:0] ctl, input int first, input int rep);
        wr(CH, ctl, 1'b1);
        wr(CH, ctl | 8'h80, 1'b0);
        t0 = cyc;
        wait_gap(12000, first);
        wait_gap(1000, rep);
        wait_gap(1000, rep);
    endtask : t_repeat_conversion

    initial begin
        repeat (5) @(posedge clock_i);
        nrst_i <= 1'b1;
        @(posedge clock_i);
        chk(analog_o, 24'h000004);
        t_regs();
        t_route();
        t_single();
        t_repeat_conversion(8'h13, 5129, 256);
        t_repeat_conversion(8'h1E, 10258, 512);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
